// file: verilog/synth_control_word_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "synth_cfw_consts.svh"
module synth_control_word_decode
    import synth_cfw_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    // Parallel byte port
    input wire logic par_wr,
    input wire logic [1:0] par_addr,
    input wire logic [7:0] par_data,
    // Serial bit port
    input wire logic ser_start,
    input wire logic ser_valid,
    input wire logic ser_bit,
    // Datapath inputs
    input wire logic frequency_update_strobe,
    input wire logic [31:0] tuning_word,
    input wire logic [31:0] delta_word,
    input wire logic [15:0] ramp_rate_word,
    // Loop inputs
    input wire logic pump_request,
    input wire logic pd_input_slower,
    input wire logic loop_unlocked,
    // Register readback
    output logic [31:0] control_function_word,
    // Pump and divider controls
    output logic [2:0] final_pump_scale,
    output logic [3:0] wide_pump_scale,
    output logic [2:0] n_ratio,
    output logic [2:0] m_ratio,
    output logic pump_offset_mode,
    output logic pump_source,
    output logic pump_sink,
    output logic fast_lock_enable,
    output logic fast_lock_active,
    // Mode controls
    output logic sweep_mode,
    output logic sine_select,
    output logic reference_clock_in_div2_bypass,
    output logic sync_clock_out,
    output logic mixer_pd,
    output logic pump_pd,
    output logic core_pd,
    output logic full_sleep,
    output logic serial_pin_bidir,
    output logic lsb_first,
    // Datapath state
    output logic [31:0] freq_acc,
    output logic [31:0] phase_acc,
    output logic [31:0] amp_phase
);

    // ----------------------------------------
    // Control word storage
    // ----------------------------------------
    word_t cfw_r;
    word_t cfw_nxt;
    word_t ser_shift_r;
    logic [4:0] ser_cnt_r;
    logic [31:0] ser_word;

    cfw_if cfw_bus ();

    assign cfw_bus.word = cfw_r;

    cfw_field_decode u_decode (
        .cfw(cfw_bus)
    );

    // ----------------------------------------
    // Serial shift register
    // ----------------------------------------
    // Serial word as it stands once the current bit is shifted in
    always_comb begin
        if (cfw_r[`CFW_LSBF]) begin
            ser_word = {ser_bit, ser_shift_r[31:1]};
        end else begin
            ser_word = {ser_shift_r[30:0], ser_bit};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ser_shift_r <= 32'h0000_0000;
            ser_cnt_r <= 5'h00;
        end else if (ser_start) begin
            ser_cnt_r <= 5'h00;
        end else if (ser_valid) begin
            ser_shift_r <= ser_word;
            ser_cnt_r <= ser_cnt_r + 5'h01;
        end
    end

    // ----------------------------------------
    // Byte and word merge
    // ----------------------------------------
    // Parallel write wins if both ports land in one cycle
    always_comb begin
        cfw_nxt = cfw_r;
        if (par_wr) begin
            if (par_addr == 2'h0) begin
                cfw_nxt[7:0] = par_data;
            end else if (par_addr == 2'h1) begin
                cfw_nxt[15:8] = par_data;
            end else if (par_addr == 2'h2) begin
                cfw_nxt[23:16] = par_data;
            end else begin
                cfw_nxt[31:24] = par_data;
            end
        end else if (ser_valid && !ser_start && ser_cnt_r == `CFW_SER_LAST) begin
            cfw_nxt = ser_word;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cfw_r <= `CFW_RESET;
        end else begin
            cfw_r <= cfw_nxt;
        end
    end

    // ----------------------------------------
    // Ramp rate timer
    // ----------------------------------------
    logic [15:0] ramp_cnt_r;
    logic ramp_expired_r;
    logic ramp_tick;
    logic core_run;

    assign core_run = !cfw_r[`CFW_PDCORE];

    always_comb begin
        ramp_tick = 1'b0;
        if (core_run && ramp_cnt_r == 16'h0000) begin
            if (cfw_r[`CFW_RTLOAD]) begin
                ramp_tick = 1'b1;
            end else if (!ramp_expired_r && !frequency_update_strobe) begin
                ramp_tick = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ramp_cnt_r <= 16'h0000;
            ramp_expired_r <= 1'b0;
        end else if (core_run) begin
            if (cfw_r[`CFW_RTLOAD]) begin
                ramp_expired_r <= 1'b0;
                if (ramp_cnt_r == 16'h0000) begin
                    ramp_cnt_r <= ramp_rate_word;
                end else begin
                    ramp_cnt_r <= ramp_cnt_r - 16'h0001;
                end
            end else if (frequency_update_strobe) begin
                ramp_cnt_r <= ramp_rate_word;
                ramp_expired_r <= 1'b0;
            end else if (ramp_cnt_r == 16'h0000) begin
                // Halts until the next update strobe
                ramp_expired_r <= 1'b1;
            end else begin
                ramp_cnt_r <= ramp_cnt_r - 16'h0001;
            end
        end
    end

    // ----------------------------------------
    // Frequency accumulator
    // ----------------------------------------
    logic [31:0] freq_acc_r;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            freq_acc_r <= 32'h0000_0000;
        end else if (cfw_r[`CFW_FCLR]) begin
            freq_acc_r <= 32'h0000_0000;
        end else if (!core_run) begin
            freq_acc_r <= freq_acc_r;
        end else if (frequency_update_strobe && cfw_r[`CFW_FAUTO]) begin
            freq_acc_r <= 32'h0000_0000;
        end else if (ramp_tick && cfw_r[`CFW_SWEEP]) begin
            freq_acc_r <= freq_acc_r + delta_word;
        end
    end

    // ----------------------------------------
    // Phase accumulator
    // ----------------------------------------
    logic [31:0] phase_acc_r;
    logic [31:0] phase_inc;

    // Sweep adds the ramped offset onto the programmed tone
    assign phase_inc = cfw_r[`CFW_SWEEP] ? (tuning_word + freq_acc_r) : tuning_word;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            phase_acc_r <= 32'h0000_0000;
        end else if (cfw_r[`CFW_PCLR]) begin
            phase_acc_r <= 32'h0000_0000;
        end else if (!core_run) begin
            phase_acc_r <= phase_acc_r;
        end else if (frequency_update_strobe && cfw_r[`CFW_PAUTO]) begin
            phase_acc_r <= 32'h0000_0000;
        end else begin
            phase_acc_r <= phase_acc_r + phase_inc;
        end
    end

    // ----------------------------------------
    // Datapath outputs
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            freq_acc <= 32'h0000_0000;
            phase_acc <= 32'h0000_0000;
            amp_phase <= `QUARTER_TURN;
        end else begin
            freq_acc <= freq_acc_r;
            phase_acc <= phase_acc_r;
            // Cosine is the sine lookup a quarter turn ahead
            if (cfw_r[`CFW_SINE]) begin
                amp_phase <= phase_acc_r;
            end else begin
                amp_phase <= phase_acc_r + `QUARTER_TURN;
            end
        end
    end

    // ----------------------------------------
    // Sync clock
    // ----------------------------------------
    logic sync_phase_r;

    // Keeps running in every power state so timing stays aligned
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sync_phase_r <= 1'b0;
        end else begin
            sync_phase_r <= !sync_phase_r;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sync_clock_out <= 1'b0;
        end else if (cfw_r[`CFW_SYNCDIS]) begin
            sync_clock_out <= 1'b0;
        end else begin
            sync_clock_out <= !sync_phase_r;
        end
    end

    // ----------------------------------------
    // Charge pump and fast lock
    // ----------------------------------------
    logic pump_live;
    logic pump_dir;
    logic ftw_far;

    assign pump_live = pump_request && !cfw_r[`CFW_PDPUMP];
    assign pump_dir = pd_input_slower ^ cfw_r[`CFW_CPPOL];
    // Coarse comparison only; fine error is left to the loop
    assign ftw_far = tuning_word[31:24] != phase_inc[31:24];

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pump_source <= 1'b0;
            pump_sink <= 1'b0;
        end else begin
            pump_source <= pump_live && pump_dir;
            pump_sink <= pump_live && !pump_dir;
        end
    end

    // ----------------------------------------
    // Fast lock decision
    // ----------------------------------------

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            fast_lock_active <= 1'b0;
        end else if (!cfw_r[`CFW_FLEN]) begin
            fast_lock_active <= 1'b0;
        end else if (cfw_r[`CFW_FLFTW]) begin
            fast_lock_active <= loop_unlocked;
        end else begin
            fast_lock_active <= loop_unlocked && ftw_far;
        end
    end

    // ----------------------------------------
    // Registered field decode
    // ----------------------------------------
    // Decode stays combinational; flops here keep outputs glitch free

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            final_pump_scale <= 3'h0;
            wide_pump_scale <= 4'h0;
            n_ratio <= 3'h1;
            m_ratio <= 3'h1;
            pump_offset_mode <= 1'b0;
            fast_lock_enable <= 1'b0;
        end else begin
            final_pump_scale <= cfw_bus.cfg.final_scale;
            wide_pump_scale <= cfw_bus.cfg.wide_scale;
            n_ratio <= cfw_bus.cfg.n_ratio;
            m_ratio <= cfw_bus.cfg.m_ratio;
            pump_offset_mode <= cfw_r[`CFW_CPOFS];
            fast_lock_enable <= cfw_r[`CFW_FLEN];
        end
    end

    // ----------------------------------------
    // Modes, power and readback
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sweep_mode <= 1'b0;
            sine_select <= 1'b0;
            reference_clock_in_div2_bypass <= 1'b0;
            mixer_pd <= 1'b1;
            pump_pd <= 1'b1;
            core_pd <= 1'b0;
            full_sleep <= 1'b0;
            serial_pin_bidir <= 1'b1;
            lsb_first <= 1'b0;
            control_function_word <= `CFW_RESET;
        end else begin
            sweep_mode <= cfw_r[`CFW_SWEEP];
            sine_select <= cfw_r[`CFW_SINE];
            reference_clock_in_div2_bypass <= cfw_r[`CFW_DIV2DIS];
            mixer_pd <= cfw_r[`CFW_PDMIX];
            pump_pd <= cfw_r[`CFW_PDPUMP];
            core_pd <= cfw_r[`CFW_PDCORE];
            full_sleep <= &cfw_r[`CFW_PDMIX:`CFW_PDCORE];
            serial_pin_bidir <= !cfw_r[`CFW_SDIOIN];
            lsb_first <= cfw_r[`CFW_LSBF];
            control_function_word <= cfw_r;
        end
    end

endmodule
`default_nettype wire

// file: verilog/synth_cfw_consts.svh
// Summary of operation
// - Final pump scale zero unless top bit set
// - Wide pump scale is twice the code
// - Auto-clear low: delta word accumulates on frequency
// - Auto-clear high: update strobe zeroes frequency accumulator once
// - Auto-clear low: tuning word accumulates on phase
// - Auto-clear high: update strobe zeroes phase accumulator once
// - Timer load low: reload ramp timer on update
// - Timer load high: reload on timeout, ignore update
// - Frequency clear bit holds accumulator at zero
// - Phase clear bit holds accumulator at zero
// - Fast-lock enable bit turns fast lock on
// - Tuning-word bit excludes tuning word from decision
// - Sweep bit selects sweep, else single tone
// - Output bit selects sine, else cosine
// - N divider: 00=1, 01=2, 1x=4
// - M divider: 00=1, 01=2, 1x=4
// - Polarity bit swaps pump source and sink
// - Offset bit selects offset pump currents
// - Divider-disable bit bypasses reference divide-by-two
// - Sync disable holds pin low, sync keeps running
// - Three power-down bits; all set means sleep
// - Core power-down stops clocks except sync output; here only the accumulators and ramp timer hold, pump outputs keep running
// - Serial pin direction: two-wire bidir, three-wire input
// - Bit-order bit selects LSB-first serial transfers
// - Serial bit positions numbered from word MSB
`ifndef SYNTH_CFW_CONSTS_SVH
`define SYNTH_CFW_CONSTS_SVH

`define CFW_RESET 32'h0000_0018
`define CFW_FPUMP_HI 29
`define CFW_FPUMP_LO 27
`define CFW_WPUMP_HI 26
`define CFW_WPUMP_LO 24
`define CFW_FAUTO 23
`define CFW_PAUTO 22
`define CFW_RTLOAD 21
`define CFW_FCLR 20
`define CFW_PCLR 19
`define CFW_FLEN 17
`define CFW_FLFTW 16
`define CFW_SWEEP 15
`define CFW_SINE 14
`define CFW_CPOFS 13
`define CFW_NDIV_HI 12
`define CFW_NDIV_LO 11
`define CFW_CPPOL 10
`define CFW_MDIV_HI 9
`define CFW_MDIV_LO 8
`define CFW_DIV2DIS 6
`define CFW_SYNCDIS 5
`define CFW_PDMIX 4
`define CFW_PDPUMP 3
`define CFW_PDCORE 2
`define CFW_SDIOIN 1
`define CFW_LSBF 0
`define CFW_SER_LAST 5'h1f
`define QUARTER_TURN 32'h4000_0000

`endif

// file: verilog/synth_cfw_pkg.sv
package synth_cfw_pkg;
    typedef logic [31:0] word_t;
    typedef struct packed {
        logic [2:0] final_scale;
        logic [3:0] wide_scale;
        logic [2:0] n_ratio;
        logic [2:0] m_ratio;
    } pump_cfg_s;
endpackage

// file: verilog/cfw_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cfw_if;
    import synth_cfw_pkg::*;
    word_t word;
    pump_cfg_s cfg;
    modport owner (output word, input cfg);
    modport decoder (input word, output cfg);
endinterface
`default_nettype wire

// file: verilog/cfw_field_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "synth_cfw_consts.svh"
module cfw_field_decode
    import synth_cfw_pkg::*;
(
    cfw_if.decoder cfw
);
    logic [2:0] fcode;
    logic [2:0] wcode;
    logic [1:0] ncode;
    logic [1:0] mcode;

    // ----------------------------------------
    // Ratio lookup shared by both dividers
    // ----------------------------------------
    function automatic logic [2:0] div_ratio(input logic [1:0] code);
        logic [2:0] r;
        r = 3'h1;
        if (code[1]) begin
            r = 3'h4;
        end else if (code[0]) begin
            r = 3'h2;
        end
        return r;
    endfunction

    always_comb begin
        fcode = cfw.word[`CFW_FPUMP_HI:`CFW_FPUMP_LO];
        wcode = cfw.word[`CFW_WPUMP_HI:`CFW_WPUMP_LO];
        ncode = cfw.word[`CFW_NDIV_HI:`CFW_NDIV_LO];
        mcode = cfw.word[`CFW_MDIV_HI:`CFW_MDIV_LO];
        cfw.cfg.final_scale = fcode[2] ? ({1'b0, fcode[1:0]} + 3'h1) : 3'h0;
        cfw.cfg.wide_scale = {wcode, 1'b0};
        cfw.cfg.n_ratio = div_ratio(ncode);
        cfw.cfg.m_ratio = div_ratio(mcode);
    end
endmodule
`default_nettype wire

// file: tb/synth_cfw_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module synth_cfw_checker (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic frequency_update_strobe,
    input wire logic pump_request,
    input wire logic pd_input_slower,
    input wire logic [31:0] control_function_word,
    input wire logic [2:0] final_pump_scale,
    input wire logic [3:0] wide_pump_scale,
    input wire logic [2:0] n_ratio,
    input wire logic [2:0] m_ratio,
    input wire logic pump_source,
    input wire logic pump_sink,
    input wire logic fast_lock_active,
    input wire logic sync_clock_out,
    input wire logic full_sleep,
    input wire logic [31:0] freq_acc,
    input wire logic [31:0] phase_acc
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    logic [31:0] w;
    assign w = control_function_word;

    AST_FINAL_SCALE: assert property (final_pump_scale == (w[29] ? 3'(w[28:27]) + 3'h1 : 3'h0))
        else $error("final pump scale wrong");
    AST_WIDE_SCALE: assert property (wide_pump_scale == {w[26:24], 1'b0})
        else $error("wide pump scale wrong");
    AST_N_RATIO: assert property (n_ratio == (w[12] ? 3'h4 : w[11] ? 3'h2 : 3'h1))
        else $error("n ratio wrong");
    AST_M_RATIO: assert property (m_ratio == (w[9] ? 3'h4 : w[8] ? 3'h2 : 3'h1))
        else $error("m ratio wrong");
    AST_FACC_HELD: assert property (w[20] [*3] |-> freq_acc == 32'h0000_0000)
        else $error("frequency accumulator not held clear");
    AST_PACC_HELD: assert property (w[19] [*3] |-> phase_acc == 32'h0000_0000)
        else $error("phase accumulator not held clear");
    AST_PACC_AUTO: assert property (frequency_update_strobe && w[22] && !w[2] && $stable(w) ##1 $stable(w)
        |-> ##1 phase_acc == 32'h0000_0000) else $error("phase auto clear missing");
    AST_SYNC_OFF: assert property (w[5] [*2] |-> !sync_clock_out)
        else $error("sync output not static");
    AST_SYNC_RUN: assert property ((!w[5]) [*3] |-> sync_clock_out != $past(sync_clock_out))
        else $error("sync output not toggling");
    AST_SLEEP: assert property (full_sleep == (w[4] && w[3] && w[2]))
        else $error("full sleep wrong");
    AST_PUMP_DIR: assert property ($stable(w) |->
        pump_source == ($past(pump_request) && !w[3] && ($past(pd_input_slower) ^ w[10]))
        && pump_sink == ($past(pump_request) && !w[3] && !($past(pd_input_slower) ^ w[10])))
        else $error("pump direction wrong");
    AST_FL_OFF: assert property ($stable(w) && !w[17] |-> !fast_lock_active)
        else $error("fast lock active while disabled");
endmodule
bind synth_control_word_decode synth_cfw_checker i_chk (.clk_sys, .srst, .frequency_update_strobe,
    .pump_request, .pd_input_slower, .control_function_word, .final_pump_scale, .wide_pump_scale,
    .n_ratio, .m_ratio, .pump_source, .pump_sink, .fast_lock_active, .sync_clock_out, .full_sleep,
    .freq_acc, .phase_acc);
`default_nettype wire

// file: tb/cfw_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module cfw_host_model (
    input wire logic clk_sys,
    output logic par_wr,
    output logic [1:0] par_addr,
    output logic [7:0] par_data,
    output logic ser_start,
    output logic ser_valid,
    output logic ser_bit
);
    initial begin
        par_wr = 1'b0;
        par_addr = 2'h0;
        par_data = 8'h00;
        ser_start = 1'b0;
        ser_valid = 1'b0;
        ser_bit = 1'b0;
    end
    // Returns once readback and decoded outputs have settled
    task automatic wr_byte(input logic [1:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        par_wr = 1'b1;
        par_addr = a;
        par_data = d;
        @(negedge clk_sys);
        par_wr = 1'b0;
        par_data = ~d;
        @(negedge clk_sys);
    endtask
    task automatic ser_word(input logic [31:0] w, input logic lsbf);
        @(negedge clk_sys);
        ser_start = 1'b1;
        for (int i = 0; i < 32; i++) begin
            @(negedge clk_sys);
            ser_start = 1'b0;
            ser_valid = 1'b1;
            ser_bit = lsbf ? w[i] : w[31 - i];
        end
        @(negedge clk_sys);
        ser_valid = 1'b0;
        ser_bit = ~ser_bit;
        @(negedge clk_sys);
    endtask
endmodule
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import synth_cfw_pkg::*;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic frequency_update_strobe = 1'b0, pump_request = 1'b0, pd_input_slower = 1'b0, loop_unlocked = 1'b0;
    logic par_wr, ser_start, ser_valid, ser_bit;
    logic [1:0] par_addr;
    logic [7:0] par_data;
    word_t tuning_word = 32'h0000_0005, delta_word = 32'h0000_0003;
    logic [15:0] ramp_rate_word = 16'h0002;
    word_t control_function_word, freq_acc, phase_acc, amp_phase, v;
    logic [2:0] final_pump_scale, n_ratio, m_ratio;
    logic [3:0] wide_pump_scale;
    logic pump_offset_mode, pump_source, pump_sink, fast_lock_enable, fast_lock_active, sweep_mode, sine_select;
    logic reference_clock_in_div2_bypass, sync_clock_out, mixer_pd, pump_pd, core_pd, full_sleep, serial_pin_bidir, lsb_first;
    int mismatches = 0;
    int checks = 0;
    always #10 clk_sys = ~clk_sys;
    synth_control_word_decode i_dut (.clk_sys, .srst, .par_wr, .par_addr, .par_data, .ser_start, .ser_valid,
        .ser_bit, .frequency_update_strobe, .tuning_word, .delta_word, .ramp_rate_word, .pump_request,
        .pd_input_slower, .loop_unlocked, .control_function_word, .final_pump_scale, .wide_pump_scale,
        .n_ratio, .m_ratio, .pump_offset_mode, .pump_source, .pump_sink, .fast_lock_enable,
        .fast_lock_active, .sweep_mode, .sine_select, .reference_clock_in_div2_bypass, .sync_clock_out, .mixer_pd,
        .pump_pd, .core_pd, .full_sleep, .serial_pin_bidir, .lsb_first, .freq_acc, .phase_acc, .amp_phase);
    cfw_host_model i_host (.clk_sys, .par_wr, .par_addr, .par_data, .ser_start, .ser_valid, .ser_bit);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input word_t got, input word_t exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        if (mismatches == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // Word left quiet first so the stored bits are settled around the pulse
    task automatic strobe;
        cyc(2);
        frequency_update_strobe = 1'b1;
        cyc(1);
        frequency_update_strobe = 1'b0;
        cyc(1);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        chk(control_function_word, 32'h0000_0018);
        chk(32'({mixer_pd, pump_pd, core_pd, serial_pin_bidir, lsb_first}), 32'h0000_001A);
        chk(32'({n_ratio, m_ratio}), 32'h0000_0009);
        chk(amp_phase, 32'h4000_0000);
    endtask
    task automatic t_pump;
        for (int c = 0; c < 8; c++) begin
            i_host.wr_byte(2'h3, 8'(c * 9));
            chk(32'(final_pump_scale), c[2] ? 32'(c[1:0]) + 32'h0000_0001 : 32'h0000_0000);
            chk(32'(wide_pump_scale), 32'(c * 2));
        end
    endtask
    task automatic t_div;
        i_host.wr_byte(2'h0, 8'h00);
        chk(32'({mixer_pd, pump_pd, core_pd}), 32'h0000_0000);
        pump_request = 1'b1;
        pd_input_slower = 1'b1;
        for (int k = 0; k < 4; k++) begin
            i_host.wr_byte(2'h1, 8'(k * 9 + (k % 2) * 4));
            v = k[1] ? 32'h0000_0004 : k[0] ? 32'h0000_0002 : 32'h0000_0001;
            chk(32'(n_ratio), v);
            chk(32'(m_ratio), v);
            chk(32'({pump_source, pump_sink}), k[0] ? 32'h0000_0001 : 32'h0000_0002);
        end
        pump_request = 1'b0;
    endtask
    task automatic t_modes;
        loop_unlocked = 1'b1;
        i_host.wr_byte(2'h2, 8'h03);
        i_host.wr_byte(2'h1, 8'hE0);
        i_host.wr_byte(2'h0, 8'h63);
        chk(32'({fast_lock_enable, fast_lock_active}), 32'h0000_0003);
        chk(32'({sweep_mode, sine_select, pump_offset_mode}), 32'h0000_0007);
        chk(32'({reference_clock_in_div2_bypass, sync_clock_out}), 32'h0000_0002);
        chk(32'({serial_pin_bidir, lsb_first}), 32'h0000_0001);
        chk(amp_phase, phase_acc);
        // No sweep offset yet, so the tuning word alone never looks far
        i_host.wr_byte(2'h2, 8'h02);
        chk(32'(fast_lock_active), 32'h0000_0000);
    endtask
    // Second frame still goes LSB first: order follows the word stored before it
    task automatic t_serial;
        word_t w [3] = '{32'h0A00_0019, 32'h0500_0018, 32'h0300_0018};
        for (int i = 0; i < 3; i++) begin
            i_host.ser_word(w[i], i < 2);
            chk(control_function_word, w[i]);
        end
    endtask
    task automatic t_accum;
        chk(amp_phase - phase_acc, 32'h4000_0000);
        v = phase_acc;
        cyc(1);
        chk(phase_acc - v, tuning_word);
        i_host.wr_byte(2'h2, 8'h18);
        cyc(3);
        chk(phase_acc, 32'h0000_0000);
        chk(freq_acc, 32'h0000_0000);
        i_host.wr_byte(2'h2, 8'h40);
        strobe();
        chk(phase_acc, 32'h0000_0000);
        cyc(1);
        chk(phase_acc, tuning_word);
        i_host.wr_byte(2'h1, 8'h80);
        i_host.wr_byte(2'h2, 8'hA0);
        cyc(20);
        chk(32'(freq_acc % 3 == 0 && freq_acc != 0), 32'h0000_0001);
        strobe();
        chk(freq_acc, 32'h0000_0000);
        i_host.wr_byte(2'h2, 8'h00);
        strobe();
        cyc(10);
        v = freq_acc;
        strobe();
        cyc(10);
        chk(freq_acc, v + delta_word);
        i_host.wr_byte(2'h0, 8'h1C);
        cyc(1);
        v = phase_acc;
        cyc(5);
        chk(phase_acc, v);
        chk(32'(full_sleep), 32'h0000_0001);
        chk(32'({mixer_pd, pump_pd, core_pd}), 32'h0000_0007);
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        test_done();
    end
    initial begin
        cyc(6);
        srst = 1'b0;
        t_reset();
        t_pump();
        t_div();
        t_modes();
        t_serial();
        t_accum();
        test_done();
    end
endmodule
`default_nettype wire
